// >>> design/pdct_pkg.sv
/*
 * constants, state type and tap decode for the prescaled down-counter timer.
 * assumes a 100 MHz core clock and an apb slave with 12 address bits.
 */
package pdct_pkg;

    localparam int CNT_W = 8;
    localparam int PRE_W = 7;
    localparam int DIV_W = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // register map: printed offsets are word indices, byte address is index * 4
    localparam logic [3:0] IDX_VALUE = 4'h8;
    localparam logic [3:0] IDX_CONTROL = 4'h9;

    // control register fields
    localparam int BIT_FLAG = 7;
    localparam int BIT_MASK = 6;
    localparam int BIT_SRC = 5;
    localparam int BIT_GATE = 4;
    localparam int BIT_CLR = 3;
    localparam int DIV_LSB = 0;

    // option byte fields
    localparam int OPT_BIT_MODE = 6;

    // bits forced to one on read in option-byte mode
    localparam logic [7:0] CTRL_OPT_ONES = 8'h37;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [CNT_W-1:0] COUNT_RESET = 8'hff;
    localparam logic [PRE_W-1:0] PRE_RESET = 7'h7f;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b1;

    // pin edge to prescaler pulse in external mode, in core cycles
    localparam int PIN_LATENCY = 3;

    // prescaler input select, coded as {gate, source}
    localparam logic [1:0] SEL_INTERNAL = 2'h0;
    localparam logic [1:0] SEL_OFF = 2'h1;
    localparam logic [1:0] SEL_GATED = 2'h2;
    localparam logic [1:0] SEL_EXTERNAL = 2'h3;

    typedef enum logic {ST_LOAD, ST_RUN} pdct_state_t;

    // low bits of the prescaler that must be zero for the selected tap to fire
    function automatic logic [PRE_W-1:0] tap_mask(input logic [DIV_W-1:0] sel);
        tap_mask = PRE_W'((8'h01 << sel) - 8'h01);
    endfunction : tap_mask

endpackage : pdct_pkg

// >>> design/pdct_pin_sense.sv
/*
 * count input pin sensing: level and re-armed rising edge.
 * assumes the pin is synchronous to mclk_in; the stages set the pin latency.
 */
`timescale 1ns/1ns
module pdct_pin_sense (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // rise needs stage3 low, so the pin must be seen low before re-arming
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            rise_out <= stage2 & ~stage3;
        end
    end

    assign level_out = stage2;

endmodule : pdct_pin_sense

// >>> design/pdct_prescaler.sv
/*
 * 7-bit binary prescaler with eight selectable taps.
 * assumes pulse_in is a one-cycle enable and clear_in a one-cycle strobe.
 */
`timescale 1ns/1ns
module pdct_prescaler (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic pulse_in,
    input wire logic clear_in,
    input wire logic [pdct_pkg::DIV_W-1:0] div_sel_in,
    output logic tick_out,
    output logic [pdct_pkg::PRE_W-1:0] count_out
);

    logic [pdct_pkg::PRE_W-1:0] count;
    logic tap_hit;

    // counts down from all ones, so a cleared prescaler gives a full period
    assign tap_hit = (count & pdct_pkg::tap_mask(div_sel_in)) == {pdct_pkg::PRE_W{1'b0}};
    // a clear swallows the pulse of its own cycle
    assign tick_out = pulse_in & ~clear_in & tap_hit;
    assign count_out = count;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= pdct_pkg::PRE_RESET;
        end else if (clear_in) begin
            count <= pdct_pkg::PRE_RESET;
        end else if (pulse_in) begin
            count <= count - 7'h01;
        end
    end

endmodule : pdct_prescaler

// >>> design/pdct_timer.sv
/*
 * prescaled 8-bit down-counter timer with apb register access.
 * assumes an apb master on mclk_in, a count pin synchronous to the clock and a
 * factory option byte that is stable from reset release onward.
 */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
// Functional notes
// - software-loadable 8-bit counter, decremented by each prescaler output pulse.
// - decrement to zero sets the count-done flag, control bit 7.
// - mask bit 6 set blocks the request; clear passes it.
// - request is a level held until software clears the flag.
// - counter wraps from zero to all ones; reads never disturb counting.
// - external source counts pin rising edges when gate is set, nothing when gate is clear; otherwise the internal clock.
// - pin change needs three cycles; pin must be seen low to re-arm. The gated-mode level path takes two cycles.
// - prescaler is a 7-bit divider with eight taps, one bypassing.
// - writing one to bit 3 resets the prescaler to all ones in software mode only.
// - reset loads ones into prescaler and counter, clears flag, sets mask.
// - bits 0,1,2,4,5 load from option byte; writable only if mode zero.
// - software mode: all bits read/write except bit 3, reading zero.
// - option mode: bits 7,6 read/write; 5,4,2,1,0 read one; bit 3 zero.
// - gate and source choose internal, gated, none or pin clock.
// - gated mode counts internal clocks only while the pin is high.
// - bits 2..0 choose the division from 1 to 128.
// - control register at index 009, flag down to division bits.
// - division code n selects divide by two to the n.
module pdct_timer (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [pdct_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [pdct_pkg::DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [pdct_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic count_pin_in,
    input wire logic [7:0] factory_option_in,
    output logic count_irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    pdct_pkg::pdct_state_t state;
    logic option_mode_select;
    logic count_done_flag;
    logic count_irq_mask;
    logic count_source_select;
    logic pin_gate_enable;
    logic [pdct_pkg::DIV_W-1:0] div_select;
    logic [pdct_pkg::CNT_W-1:0] count_value;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire setup_phase;
    wire access_done;
    wire addr_aligned;
    wire hit_value;
    wire hit_ctrl;
    wire wr_value;
    wire wr_ctrl;
    wire [7:0] wdata_lo;
    wire [7:0] ctrl_raw;
    wire [7:0] ctrl_read;
    wire [pdct_pkg::DATA_W-1:0] next_rdata;

    assign setup_phase = psel_in & ~penable_in;
    assign access_done = psel_in & penable_in & pready_out;
    assign addr_aligned = (paddr_in[11:6] == 6'h00) && (paddr_in[1:0] == 2'h0);
    assign hit_value = addr_aligned && (paddr_in[5:2] == pdct_pkg::IDX_VALUE);
    assign hit_ctrl = addr_aligned && (paddr_in[5:2] == pdct_pkg::IDX_CONTROL);
    // only byte lane 0 carries register bits
    assign wr_value = access_done & pwrite_in & hit_value & pstrb_in[0];
    assign wr_ctrl = access_done & pwrite_in & hit_ctrl & pstrb_in[0];
    assign wdata_lo = pwdata_in[7:0];

    // bit 3 always reads zero so bit set/clear instructions stay safe
    assign ctrl_raw = {count_done_flag, count_irq_mask, count_source_select,
                       pin_gate_enable, 1'b0, div_select};
    assign ctrl_read = option_mode_select ? (ctrl_raw | pdct_pkg::CTRL_OPT_ONES)
                                          : ctrl_raw;
    // reads sample the live count and have no side effect
    assign next_rdata = hit_value ? {24'h000000, count_value} :
                        hit_ctrl ? {24'h000000, ctrl_read} : 32'h00000000;

    // one wait-free access: ready is set during setup, answered in access
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= setup_phase;
            pslverr_out <= setup_phase & ~(hit_value | hit_ctrl);
            if (setup_phase && !pwrite_in) begin
                prdata_out <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration: option byte capture after reset release, then software

    wire running;
    wire cfg_write;
    wire clear_strobe;

    assign running = (state == pdct_pkg::ST_RUN);
    assign cfg_write = wr_ctrl & running & ~option_mode_select;
    // the clear has no effect in option-byte mode
    assign clear_strobe = wr_ctrl & wdata_lo[pdct_pkg::BIT_CLR] & ~option_mode_select;

    // option byte is a level, so it is caught by a clocked step after reset
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= pdct_pkg::ST_LOAD;
            option_mode_select <= 1'b0;
            count_source_select <= 1'b0;
            pin_gate_enable <= 1'b0;
            div_select <= 3'h0;
        end else begin
            case (state)
                pdct_pkg::ST_LOAD: begin
                    option_mode_select <= factory_option_in[pdct_pkg::OPT_BIT_MODE];
                    count_source_select <= factory_option_in[pdct_pkg::BIT_SRC];
                    pin_gate_enable <= factory_option_in[pdct_pkg::BIT_GATE];
                    div_select <= factory_option_in[pdct_pkg::DIV_LSB +: pdct_pkg::DIV_W];
                    state <= pdct_pkg::ST_RUN;
                end
                pdct_pkg::ST_RUN: begin
                    if (cfg_write) begin
                        count_source_select <= wdata_lo[pdct_pkg::BIT_SRC];
                        pin_gate_enable <= wdata_lo[pdct_pkg::BIT_GATE];
                        div_select <= wdata_lo[pdct_pkg::DIV_LSB +: pdct_pkg::DIV_W];
                    end
                end
                default: begin
                    state <= pdct_pkg::ST_LOAD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler input selection

    wire pin_level;
    wire pin_rise;
    wire [1:0] input_sel;
    logic presc_pulse;
    wire presc_tick;
    wire [pdct_pkg::PRE_W-1:0] presc_count;

    pdct_pin_sense u_pin (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .pin_in(count_pin_in),
        .level_out(pin_level),
        .rise_out(pin_rise)
    );

    assign input_sel = {pin_gate_enable, count_source_select};

    always_comb begin
        case (input_sel)
            pdct_pkg::SEL_INTERNAL: presc_pulse = running;
            pdct_pkg::SEL_GATED: presc_pulse = running & pin_level;
            pdct_pkg::SEL_OFF: presc_pulse = 1'b0;
            pdct_pkg::SEL_EXTERNAL: presc_pulse = running & pin_rise;
            default: presc_pulse = 1'b0;
        endcase
    end

    pdct_prescaler u_presc (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .pulse_in(presc_pulse),
        .clear_in(clear_strobe),
        .div_sel_in(div_select),
        .tick_out(presc_tick),
        .count_out(presc_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // counter, flag, mask and request

    wire zero_event;
    wire [7:0] next_count;
    wire next_flag;
    wire next_mask;

    // a load in the same cycle as a tick wins and raises no event
    assign zero_event = presc_tick & ~wr_value & (count_value == 8'h01);
    assign next_count = wr_value ? wdata_lo :
                        presc_tick ? count_value - 8'h01 : count_value;
    // hardware set wins over a software clear in the same cycle
    assign next_flag = zero_event ? 1'b1 :
                       wr_ctrl ? wdata_lo[pdct_pkg::BIT_FLAG] : count_done_flag;
    assign next_mask = wr_ctrl ? wdata_lo[pdct_pkg::BIT_MASK] : count_irq_mask;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_value <= pdct_pkg::COUNT_RESET;
            count_done_flag <= pdct_pkg::FLAG_RESET;
            count_irq_mask <= pdct_pkg::MASK_RESET;
            count_irq_out <= 1'b0;
        end else begin
            count_value <= next_count;
            count_done_flag <= next_flag;
            count_irq_mask <= next_mask;
            // built from next values so it tracks the two bits in the same cycle
            count_irq_out <= next_flag & ~next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    wire ctrl_read_done;
    assign ctrl_read_done = access_done & ~pwrite_in & hit_ctrl;

    a_irq_tracks_bits: assert property (
        count_irq_out == (count_done_flag && !count_irq_mask))
        else $error("request line differs from flag and mask");

    a_flag_on_zero: assert property (
        zero_event |=> count_done_flag && (count_value == 8'h00))
        else $error("flag not set when count reached zero");

    a_wrap_to_ones: assert property (
        presc_tick && !wr_value && (count_value == 8'h00) |=> count_value == 8'hff)
        else $error("counter did not wrap to all ones");

    a_count_steps: assert property (
        presc_tick && !wr_value |=> count_value == $past(count_value) - 8'h01)
        else $error("counter did not step down by one");

    a_count_holds: assert property (
        !presc_tick && !wr_value |=> $stable(count_value))
        else $error("counter moved without a tick or load");

    a_flag_sticky: assert property (
        count_done_flag && !wr_ctrl |=> count_done_flag)
        else $error("flag dropped without a software write");

    a_clr_reads_zero: assert property (
        ctrl_read_done |-> prdata_out[pdct_pkg::BIT_CLR] == 1'b0)
        else $error("control bit 3 read as one");

    a_opt_reads_ones: assert property (
        ctrl_read_done && option_mode_select |-> prdata_out[5:4] == 2'h3
            && prdata_out[2:0] == 3'h7)
        else $error("option mode fields did not read as one");

    a_opt_no_write: assert property (
        wr_ctrl && option_mode_select |=> $stable(div_select)
            && $stable(pin_gate_enable) && $stable(count_source_select))
        else $error("option mode field changed on a write");

    a_off_no_pulse: assert property (
        input_sel == pdct_pkg::SEL_OFF |-> !presc_pulse)
        else $error("prescaler pulsed while disabled");

    a_gate_low_idle: assert property (
        input_sel == pdct_pkg::SEL_GATED && !pin_level |-> !presc_pulse)
        else $error("gated mode counted with the pin low");

    a_pin_latency: assert property (
        !count_pin_in [*3] ##1 count_pin_in |-> ##3 pin_rise)
        else $error("pin edge not seen after three cycles");

    a_presc_cleared: assert property (
        clear_strobe |=> presc_count == pdct_pkg::PRE_RESET)
        else $error("prescaler not reset by the clear strobe");

    a_bypass_every: assert property (
        div_select == 3'h0 && presc_pulse && !clear_strobe |-> presc_tick)
        else $error("bypass tap missed a pulse");

    a_ready_after_setup: assert property (
        setup_phase |=> pready_out)
        else $error("no ready in the cycle after setup");

    a_ready_one_cycle: assert property (
        pready_out |=> !pready_out)
        else $error("ready stood longer than one access cycle");

    a_err_unmapped: assert property (
        access_done && !(hit_value || hit_ctrl) |-> pslverr_out)
        else $error("unmapped access answered without an error");

    a_rdata_upper: assert property (
        access_done && !pwrite_in |-> prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    a_value_load: assert property (
        wr_value |=> count_value == $past(wdata_lo))
        else $error("counter not loaded by a software write");

    a_mask_written: assert property (
        wr_ctrl |=> count_irq_mask == $past(wdata_lo[pdct_pkg::BIT_MASK]))
        else $error("mask bit did not take the written value");

    a_flag_written: assert property (
        wr_ctrl && !zero_event |=> count_done_flag == $past(wdata_lo[pdct_pkg::BIT_FLAG]))
        else $error("flag did not take the written value");

    a_irq_off_masked: assert property (
        count_irq_mask |-> !count_irq_out)
        else $error("request raised while masked");

    a_presc_steps: assert property (
        presc_pulse && !clear_strobe |=> presc_count == $past(presc_count) - 7'h01)
        else $error("prescaler did not step down on a pulse");

    a_pin_rearm: assert property (
        pin_rise |=> !pin_rise)
        else $error("pin edge seen twice without re-arming");

    a_clear_no_tick: assert property (
        clear_strobe |-> !presc_tick)
        else $error("tick passed in a prescaler clear cycle");

    a_opt_no_clear: assert property (
        wr_ctrl && option_mode_select |-> !clear_strobe)
        else $error("prescaler clear acted in option mode");

    a_gated_counts: assert property (
        input_sel == pdct_pkg::SEL_GATED && pin_level && running |-> presc_pulse)
        else $error("gated mode missed a clock with the pin high");

    c_zero_event: cover property (zero_event && !count_irq_mask);
    c_ext_tick: cover property (input_sel == pdct_pkg::SEL_EXTERNAL && presc_tick);
    c_gated_tick: cover property (input_sel == pdct_pkg::SEL_GATED && presc_tick);
    c_set_beats_clear: cover property (zero_event && wr_ctrl);
    c_count_wrap: cover property (presc_tick && !wr_value && count_value == 8'h00);

endmodule : pdct_timer

// >>> tb/pdct_pin_model.sv
/*
 * count pin partner: drives the external count input as a pulse train.
 * assumes it is driven from the core clock, so the pin stays synchronous.
 */
`timescale 1ns/1ns
module pdct_pin_model (
    input wire logic mclk_in,
    output logic pin_out
);
    initial pin_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // one pulse; levels shorter than two cycles are stretched to two
    task automatic pulse(input int hi_len, input int lo_len);
        if (hi_len < 2) hi_len = 2;
        if (lo_len < 2) lo_len = 2;
        @(posedge mclk_in);
        pin_out <= 1'b1;
        repeat (hi_len) @(posedge mclk_in);
        pin_out <= 1'b0;
        repeat (lo_len - 1) @(posedge mclk_in);
    endtask : pulse
endmodule : pdct_pin_model

// >>> tb/testbench.sv
/*
 * self-checking bench for the timer: apb master, pin partner, integer model.
 * assumes the register map at byte addresses 0x20 and 0x24 and a 100 MHz clock.
 */
`timescale 1ns/1ns
module testbench;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [pdct_pkg::ADDR_W-1:0] paddr_in = 12'h000;
    logic [pdct_pkg::DATA_W-1:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hf;
    logic [pdct_pkg::DATA_W-1:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic count_pin_in;
    logic [7:0] factory_option_in = 8'h20;
    logic count_irq_out;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int total_checks = 0;
    int seed = 32'h0e40;
    int m_ctrl, m_cnt, m_pre, k, diff;
    logic m_opt;
    time t0;
    int irq_seq[3] = '{8'hf0, 8'hb0, 8'h30};

    always #5 mclk_in = ~mclk_in;

    pdct_timer DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .count_pin_in(count_pin_in),
        .factory_option_in(factory_option_in), .count_irq_out(count_irq_out));
    pdct_pin_model u_pin (.mclk_in(mclk_in), .pin_out(count_pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; waits on pready, bounded
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wdata;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    ////////////////////////////////////////////////////////////////////////////////
    // integer model of control, counter and prescaler
    function automatic int exp_ctrl();
        return m_opt ? ((m_ctrl & 8'hc0) | 8'h37) : m_ctrl;
    endfunction : exp_ctrl

    function automatic void model_pulse();
        if ((m_pre & ((1 << (m_ctrl & 7)) - 1)) == 0) begin
            m_cnt = (m_cnt - 1) & 8'hff;
            if (m_cnt == 0) m_ctrl = m_ctrl | 8'h80;
        end
        m_pre = (m_pre - 1) & 7'h7f;
    endfunction : model_pulse

    task automatic pin_pulse(input int hi_len, input int lo_len);
        u_pin.pulse(hi_len, lo_len);
        if (((m_ctrl >> 4) & 3) == 3) model_pulse();
        repeat (4) @(posedge mclk_in);
    endtask : pin_pulse

    task automatic wr_ctrl(input int d);
        apb(1'b1, 12'h024, 32'(d));
        m_ctrl = m_opt ? ((d & 8'hc0) | (m_ctrl & 8'h37)) : (d & 8'hf7);
        if (!m_opt && d[3]) m_pre = 7'h7f;
        repeat (2) @(posedge mclk_in);
    endtask : wr_ctrl

    task automatic wr_val(input int d);
        apb(1'b1, 12'h020, 32'(d));
        m_cnt = d;
    endtask : wr_val

    task automatic rd_chk(input logic [11:0] addr, input int exp);
        apb(1'b0, addr, 32'h0);
        check(rd, 32'(exp));
    endtask : rd_chk

    task automatic do_reset(input logic [7:0] opt);
        arst_n_in <= 1'b0;
        factory_option_in <= opt;
        repeat (20) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        m_opt = opt[6];
        m_ctrl = 8'h40 | (opt & 8'h37);
        m_cnt = 8'hff;
        m_pre = 7'h7f;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk_in);
        fails++;
        complete_run();
    end

    initial begin
        do_reset(8'h20);
        rd_chk(12'h024, exp_ctrl());
        rd_chk(12'h020, m_cnt);
        check(count_irq_out, 1'b0);
        apb(1'b0, 12'h030, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        // a write without byte lane 0 must leave the counter alone
        pstrb_in <= 4'he;
        apb(1'b1, 12'h020, 32'h0);
        pstrb_in <= 4'hf;
        rd_chk(12'h020, m_cnt);
        wr_ctrl(8'h2d);
        rd_chk(12'h024, exp_ctrl());
        $display("test reset and access done");
        wr_val(8'h03);
        wr_ctrl(8'h38);
        repeat (3) pin_pulse(3, 3);
        rd_chk(12'h020, m_cnt);
        rd_chk(12'h024, exp_ctrl());
        check(count_irq_out, 1'b1);
        pin_pulse(3, 3);
        rd_chk(12'h020, m_cnt);
        foreach (irq_seq[i]) begin
            wr_ctrl(irq_seq[i]);
            check(count_irq_out, 1'(m_ctrl[7] & ~m_ctrl[6]));
        end
        $display("test external count and request done");
        for (int n = 0; n < 8; n++) begin
            wr_val(8'h50);
            wr_ctrl(8'h38 | n);
            repeat ((1 << n) - 1) pin_pulse(2, 2);
            rd_chk(12'h020, m_cnt);
            pin_pulse(2, 2);
            rd_chk(12'h020, m_cnt);
        end
        $display("test prescaler taps done");
        wr_ctrl(8'h18);
        wr_val(8'h80);
        k = 5 + ($unsigned($random(seed)) % 16);
        u_pin.pulse(k, 3);
        repeat (4) @(posedge mclk_in);
        apb(1'b0, 12'h020, 32'h0);
        diff = 8'h80 - int'(rd[7:0]);
        check(32'(diff >= k - 1 && diff <= k + 1), 32'h1);
        $display("test gated count done");
        wr_ctrl(8'h0f);
        t0 = $time;
        wr_val(8'h40);
        repeat (4) u_pin.pulse(2 + ($unsigned($random(seed)) % 8), 2);
        // one divide-by-128 tick lands between cycle 128 and 256 after the clear
        while ($time - t0 < 2000) @(posedge mclk_in);
        rd_chk(12'h020, 8'h3f);
        $display("test internal clock done");
        do_reset(8'h65);
        rd_chk(12'h024, exp_ctrl());
        wr_ctrl(8'h00);
        rd_chk(12'h024, exp_ctrl());
        wr_val(8'h05);
        pin_pulse(3, 3);
        rd_chk(12'h020, m_cnt);
        $display("test option mode done");
        complete_run();
    end
endmodule : testbench
